// ### include/lpm_defs.svh
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH
`define LPM_NUM_WAKE 19
`define LPM_NUM_PINS 16
`define LPM_CLK_MHZ 50
// Supply ramp wait in ns, and backup wake limit in ns
`define LPM_SUPPLY_NS 2000
`define LPM_BACKUP_WAKE_NS 100000
`define LPM_WAIT_WAKE_NS 10000
`define LPM_RC_START_NS 1000
`define LPM_SUPPLY_CYC ((`LPM_SUPPLY_NS * `LPM_CLK_MHZ + 999) / 1000)
`define LPM_RC_CYC ((`LPM_RC_START_NS * `LPM_CLK_MHZ + 999) / 1000)
`define LPM_RESET_CYC 16
`endif

// ### include/lpm_pkg.sv
package lpm_pkg;
   typedef enum logic [2:0] {
      ST_RUN, ST_SLEEP, ST_WAIT, ST_BACKUP, ST_SUPPLY_UP, ST_RC_START,
      ST_CORE_RESET
   } lpm_state_t;
   typedef enum logic [1:0] {
      CLK_SRC_RC, CLK_SRC_XTAL, CLK_SRC_PLL
   } clk_src_t;
endpackage : lpm_pkg

// ### hw/wake_detect.sv
`timescale 1ns/1ps
`include "lpm_defs.svh"
// ----------------------------------------
// Wake source qualification and sync
// ----------------------------------------
module wake_detect #(
   parameter int N = `LPM_NUM_WAKE
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Raw sources, active low, and enables
   input wire logic [N-1:0] wake_n_in,
   input wire logic [N-1:0] wake_en_in,
   // Results
   output logic fast_req_async_out,
   output logic wake_sync_out
);
   logic [N-1:0] hit;
   logic s1_q, s2_q;
   logic s1_d, s2_d;
   assign hit = ~wake_n_in & wake_en_in;
   assign fast_req_async_out = |hit;
   always_comb begin
      s1_d = fast_req_async_out;
      s2_d = s1_q;
   end
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end
   assign wake_sync_out = s2_q;
endmodule : wake_detect

// ### hw/low_power_mode_wakeup_ctrl.sv
`timescale 1ns/1ps
`include "lpm_defs.svh"
module low_power_mode_wakeup_ctrl (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Processor core
   input wire logic wait_for_interrupt_instr_in,
   input wire logic wait_for_event_instr_in,
   input wire logic deep_sleep_select_in,
   input wire logic irq_in,
   input wire logic event_in,
   // Fast startup mode configuration
   input wire logic low_power_select_in,
   input wire logic [`LPM_NUM_WAKE-1:0] wake_enable_in,
   // Wake inputs: pins, supply monitor, rtc, real time timer, active low
   input wire logic [`LPM_NUM_PINS-1:0] wake_up_pins_n_in,
   input wire logic supply_monitor_alarm_n_in,
   input wire logic rtc_alarm_n_in,
   input wire logic real_time_timer_alarm_n_in,
   // Clock and power controls
   output logic core_clk_en_out,
   output logic periph_clk_en_out,
   output logic regulator_en_out,
   output logic core_supply_en_out,
   output logic sram_supply_en_out,
   output logic fast_rc_en_out,
   output lpm_pkg::clk_src_t master_clock_src_out,
   output logic fast_startup_req_out,
   // Core reset and pad state
   output logic core_reset_n_out,
   output logic io_hold_out,
   output logic io_ports_default_out,
   output lpm_pkg::lpm_state_t mode_out
);
   import lpm_pkg::*;

   localparam int SUP_CYC = `LPM_SUPPLY_CYC;
   localparam int RC_CYC = `LPM_RC_CYC;
   localparam int RST_CYC = `LPM_RESET_CYC;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic cnt_at(input logic [11:0] c, input int n);
      return c == 12'(n - 1);
   endfunction : cnt_at

   // ----------------------------------------
   // Wake detection
   // ----------------------------------------
   logic [`LPM_NUM_WAKE-1:0] wake_n;
   logic fast_req, wake_sync;
   assign wake_n = {real_time_timer_alarm_n_in, rtc_alarm_n_in,
                    supply_monitor_alarm_n_in, wake_up_pins_n_in};

   wake_detect #(.N(`LPM_NUM_WAKE)) u_wake (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .wake_n_in(wake_n),
      .wake_en_in(wake_enable_in),
      .fast_req_async_out(fast_req),
      .wake_sync_out(wake_sync)
   );

   // ----------------------------------------
   // Mode state machine
   // ----------------------------------------
   lpm_state_t state_q, state_d;
   logic by_wfi_q, by_wfi_d;
   logic [11:0] cnt_q, cnt_d;
   clk_src_t src_q, src_d;
   logic sup_on_q, sup_on_d;
   logic ports_def_q, ports_def_d;
   logic rc_on_q, rc_on_d;

   always_comb begin
      state_d = state_q;
      by_wfi_d = by_wfi_q;
      cnt_d = cnt_q;
      src_d = src_q;
      sup_on_d = sup_on_q;
      ports_def_d = ports_def_q;
      rc_on_d = rc_on_q;
      case (state_q)
         ST_RUN: begin
            cnt_d = 12'h000;
            if (wait_for_event_instr_in && deep_sleep_select_in) begin
               state_d = ST_BACKUP;
               sup_on_d = 1'b0;
            end else if (wait_for_event_instr_in && low_power_select_in) begin
               state_d = ST_WAIT;
               rc_on_d = 1'b0;
            end else if ((wait_for_event_instr_in ||
                          wait_for_interrupt_instr_in) &&
                         !deep_sleep_select_in) begin
               state_d = ST_SLEEP;
               by_wfi_d = wait_for_interrupt_instr_in;
            end
         end
         ST_SLEEP: begin
            if (by_wfi_q ? irq_in : event_in) begin
               state_d = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (wake_sync || event_in) begin
               state_d = ST_RC_START;
            end
         end
         ST_BACKUP: begin
            if (wake_sync) begin
               state_d = ST_SUPPLY_UP;
               sup_on_d = 1'b1;
            end
         end
         ST_SUPPLY_UP: begin
            sup_on_d = 1'b1;
            if (cnt_at(cnt_q, SUP_CYC)) begin
               cnt_d = 12'h000;
               state_d = ST_RC_START;
            end else begin
               cnt_d = cnt_q + 12'h001;
            end
         end
         ST_RC_START: begin
            rc_on_d = 1'b1;
            src_d = CLK_SRC_RC;
            if (cnt_at(cnt_q, RC_CYC)) begin
               cnt_d = 12'h000;
               if (!sup_on_q || ports_def_q) begin
                  state_d = ST_RUN;
               end else begin
                  state_d = ST_RUN;
               end
            end else begin
               cnt_d = cnt_q + 12'h001;
            end
         end
         ST_CORE_RESET: begin
            if (cnt_at(cnt_q, RST_CYC)) begin
               cnt_d = 12'h000;
               state_d = ST_RUN;
            end else begin
               cnt_d = cnt_q + 12'h001;
            end
         end
         default: state_d = ST_RUN;
      endcase
      if (state_q == ST_RC_START && cnt_at(cnt_q, RC_CYC) &&
          ports_def_q) begin
         state_d = ST_CORE_RESET;
      end
      if (state_q == ST_BACKUP && wake_sync) begin
         ports_def_d = 1'b1;
      end else if (state_q == ST_CORE_RESET &&
                   cnt_at(cnt_q, RST_CYC)) begin
         ports_def_d = 1'b0;
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_q <= ST_RUN;
         by_wfi_q <= 1'b0;
         cnt_q <= 12'h000;
         src_q <= CLK_SRC_RC;
         sup_on_q <= 1'b1;
         ports_def_q <= 1'b0;
         rc_on_q <= 1'b1;
      end else begin
         state_q <= state_d;
         by_wfi_q <= by_wfi_d;
         cnt_q <= cnt_d;
         src_q <= src_d;
         sup_on_q <= sup_on_d;
         ports_def_q <= ports_def_d;
         rc_on_q <= rc_on_d;
      end
   end

   // ----------------------------------------
   // Clock controls
   // ----------------------------------------
   // Sleep halts core clock only
   assign core_clk_en_out = (state_q == ST_RUN);
   assign periph_clk_en_out = (state_q == ST_RUN) ||
                              (state_q == ST_SLEEP);

   // ----------------------------------------
   // Supply controls
   // ----------------------------------------
   assign regulator_en_out = sup_on_q;
   assign core_supply_en_out = sup_on_q;
   assign sram_supply_en_out = sup_on_q;
   assign fast_rc_en_out = rc_on_q ||
                           (state_q == ST_WAIT && fast_req);
   assign master_clock_src_out = src_q;
   assign fast_startup_req_out = (state_q == ST_WAIT) && fast_req;

   // ----------------------------------------
   // Core reset and pads
   // ----------------------------------------
   assign core_reset_n_out = (state_q != ST_CORE_RESET) && sup_on_q;
   // Hold pad state in low power
   assign io_hold_out = (state_q != ST_RUN) && (state_q != ST_CORE_RESET);
   assign io_ports_default_out = ports_def_q;
   assign mode_out = state_q;
endmodule : low_power_mode_wakeup_ctrl

// ### tb/lpm_monitor.sv
`timescale 1ns/1ps
`include "lpm_defs.svh"
module lpm_monitor (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Core side and wake inputs
   input wire logic wait_for_interrupt_instr_in,
   input wire logic wait_for_event_instr_in,
   input wire logic deep_sleep_select_in,
   input wire logic low_power_select_in,
   input wire logic [`LPM_NUM_WAKE-1:0] wake_enable_in,
   input wire logic [`LPM_NUM_PINS-1:0] wake_up_pins_n_in,
   input wire logic supply_monitor_alarm_n_in,
   input wire logic rtc_alarm_n_in,
   input wire logic real_time_timer_alarm_n_in,
   // Controls
   input wire logic core_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic regulator_en_out,
   input wire logic core_supply_en_out,
   input wire logic sram_supply_en_out,
   input wire logic fast_rc_en_out,
   input wire logic fast_startup_req_out,
   input wire logic io_ports_default_out,
   input wire lpm_pkg::lpm_state_t mode_out
);
   import lpm_pkg::*;
   logic quiet;
   assign quiet = &({real_time_timer_alarm_n_in, rtc_alarm_n_in,
      supply_monitor_alarm_n_in, wake_up_pins_n_in} | ~wake_enable_in);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   property p_sleep_clk;
      mode_out == ST_SLEEP |-> !core_clk_en_out && periph_clk_en_out;
   endproperty
   a_sleep_clk: assert property (p_sleep_clk)
      else $error("sleep clock gating wrong");
   property p_sleep_in;
      mode_out == ST_RUN && !deep_sleep_select_in && !low_power_select_in
      && (wait_for_interrupt_instr_in || wait_for_event_instr_in)
      |=> mode_out == ST_SLEEP;
   endproperty
   a_sleep_in: assert property (p_sleep_in)
      else $error("sleep not entered");
   property p_wait_in;
      mode_out == ST_RUN && wait_for_event_instr_in && low_power_select_in
      && !deep_sleep_select_in |=> mode_out == ST_WAIT;
   endproperty
   a_wait_in: assert property (p_wait_in)
      else $error("wait not entered");
   property p_backup_in;
      mode_out == ST_RUN && wait_for_event_instr_in && deep_sleep_select_in
      |=> mode_out == ST_BACKUP && !regulator_en_out && !core_supply_en_out;
   endproperty
   a_backup_in: assert property (p_backup_in)
      else $error("backup not entered with supplies off");
   property p_backup_stay;
      (mode_out == ST_BACKUP && quiet) [*4] |=> mode_out == ST_BACKUP;
   endproperty
   a_backup_stay: assert property (p_backup_stay)
      else $error("backup left without enabled wake");
   property p_fast_req;
      fast_startup_req_out == (mode_out == ST_WAIT && !quiet);
   endproperty
   a_fast_req: assert property (p_fast_req)
      else $error("fast startup request wrong");
   property p_supply_up;
      mode_out == ST_BACKUP ##1 mode_out != ST_BACKUP |-> mode_out ==
      ST_SUPPLY_UP && core_supply_en_out && sram_supply_en_out
      && io_ports_default_out;
   endproperty
   a_supply_up: assert property (p_supply_up)
      else $error("backup wake did not power up");
   property p_wait_lat;
      mode_out == ST_WAIT && !quiet |-> fast_rc_en_out ##[1:500]
      core_clk_en_out;
   endproperty
   a_wait_lat: assert property (p_wait_lat)
      else $error("wait wake too slow");
endmodule : lpm_monitor
bind low_power_mode_wakeup_ctrl lpm_monitor u_mon (.*);

// ### tb/core_model.sv
`timescale 1ns/1ps
module core_model (
   input wire logic mclk_in,
   output logic int_instr_out,
   output logic evt_instr_out,
   output logic deep_sel_out,
   output logic low_sel_out,
   output logic irq_out,
   output logic event_out
);
   initial begin
      {int_instr_out, evt_instr_out, deep_sel_out} = 3'h0;
      {low_sel_out, irq_out, event_out} = 3'h0;
   end
   task automatic exec(input logic intr, input logic ds, input logic lps);
      @(posedge mclk_in);
      deep_sel_out <= ds;
      low_sel_out <= lps;
      int_instr_out <= intr;
      evt_instr_out <= !intr;
      @(posedge mclk_in);
      int_instr_out <= 1'b0;
      evt_instr_out <= 1'b0;
   endtask : exec
   task automatic wake(input logic i, input logic e);
      @(posedge mclk_in);
      irq_out <= i;
      event_out <= e;
   endtask : wake
endmodule : core_model

// ### tb/low_power_mode_wakeup_ctrl_tb.sv
`timescale 1ns/1ps
`include "lpm_defs.svh"
module low_power_mode_wakeup_ctrl_tb;
   import lpm_pkg::*;
   logic mclk_in, rst_n_in, ii, ei, ds, ls, irq, ev, cclk, pclk, rc, req;
   logic hold, crst, pdef;
   logic [`LPM_NUM_WAKE-1:0] en, wk_n, mask;
   clk_src_t src;
   lpm_state_t mode, prev;
   lpm_state_t exp_q[$];
   int fails, samples_checked, seed, idx, pick, oth;
   core_model u_core (.mclk_in(mclk_in), .int_instr_out(ii),
      .evt_instr_out(ei), .deep_sel_out(ds), .low_sel_out(ls),
      .irq_out(irq), .event_out(ev));
   low_power_mode_wakeup_ctrl u_dut (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .wait_for_interrupt_instr_in(ii),
      .wait_for_event_instr_in(ei), .deep_sleep_select_in(ds),
      .irq_in(irq), .event_in(ev), .low_power_select_in(ls),
      .wake_enable_in(en), .wake_up_pins_n_in(wk_n[15:0]),
      .supply_monitor_alarm_n_in(wk_n[16]), .rtc_alarm_n_in(wk_n[17]),
      .real_time_timer_alarm_n_in(wk_n[18]), .core_clk_en_out(cclk),
      .periph_clk_en_out(pclk), .regulator_en_out(),
      .core_supply_en_out(), .sram_supply_en_out(), .fast_rc_en_out(rc),
      .master_clock_src_out(src), .fast_startup_req_out(req),
      .core_reset_n_out(crst), .io_hold_out(hold),
      .io_ports_default_out(pdef), .mode_out(mode));
   task check(input string what, input logic [2:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task conclude;
      $display("checked %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task wait_mode(input lpm_state_t m);
      for (int n = 0; n < 400 && mode !== m; n++) @(negedge mclk_in);
      if (mode !== m) begin
         fails++;
         conclude();
      end
   endtask : wait_mode
   // Every mode change must match the oldest expected note
   always @(negedge mclk_in) begin
      prev <= mode;
      if (rst_n_in && mode !== prev) begin
         if (exp_q.size() == 0) check("mode", mode, 3'h7);
         else check("mode", mode, exp_q.pop_front());
      end
   end
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   initial begin
      seed = 32'hEAEE;
      rst_n_in = 1'b0;
      en = '1;
      wk_n = '1;
      repeat (3) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (idx = 0; idx < 2; idx++) begin
         exp_q.push_back(ST_SLEEP);
         u_core.exec(idx == 0, 1'b0, 1'b0);
         wait_mode(ST_SLEEP);
         check("core clk", {2'h0, cclk}, 3'h0);
         check("periph clk", {2'h0, pclk}, 3'h1);
         check("hold", {2'h0, hold}, 3'h1);
         exp_q.push_back(ST_RUN);
         u_core.wake(idx == 0, idx == 1);
         wait_mode(ST_RUN);
         u_core.wake(1'b0, 1'b0);
      end
      for (idx = 0; idx < 6; idx++) begin
         pick = $unsigned($random(seed)) % `LPM_NUM_WAKE;
         oth = (pick + 1) % `LPM_NUM_WAKE;
         mask = `LPM_NUM_WAKE'($random(seed));
         mask[pick] = 1'b1;
         mask[oth] = 1'b0;
         en <= mask;
         exp_q.push_back(idx[0] ? ST_BACKUP : ST_WAIT);
         u_core.exec(1'b0, idx[0], 1'b1);
         wait_mode(idx[0] ? ST_BACKUP : ST_WAIT);
         @(posedge mclk_in) wk_n[oth] <= 1'b0;
         repeat (6) @(posedge mclk_in);
         check("req idle", {2'h0, req}, 3'h0);
         if (idx[0]) exp_q = '{ST_SUPPLY_UP, ST_RC_START, ST_CORE_RESET};
         else exp_q = '{ST_RC_START};
         exp_q.push_back(ST_RUN);
         @(posedge mclk_in) wk_n <= ~(`LPM_NUM_WAKE'(1) << pick);
         @(negedge mclk_in);
         check("req", {2'h0, req}, {2'h0, !idx[0]});
         if (idx[0]) begin
            wait_mode(ST_CORE_RESET);
            check("core rst", {2'h0, crst}, 3'h0);
            check("ports def", {2'h0, pdef}, 3'h1);
         end
         wait_mode(ST_RUN);
         check("src", 3'(src), 3'(CLK_SRC_RC));
         check("rc on", {2'h0, rc}, 3'h1);
         @(posedge mclk_in) wk_n <= '1;
      end
      repeat (5) @(posedge mclk_in);
      conclude();
   end
endmodule : low_power_mode_wakeup_ctrl_tb
